/* hdl/rbe_seq.sv */
// exception sequencer: status strobe, reset sequence, bus fault handling
// assumes AHB-Lite single word transfers and a core that reports events
// Notes on behaviour
// - 256 vectors: 64 fixed, 192 user
// - vector address is base plus number times four
// - boundary, next instruction starts: strobe one clock
// - boundary with pending trace/interrupt: two clocks
// - miss or listed exception start: three clocks
// - double fault halt: strobe held continuously
// - execution-caused exceptions give no strobe
// - reset highest priority, aborts everything
// - reset clears trace, master; sets supervisor
// - reset sets priority mask to seven
// - reset zeroes vector base
// - reset clears cache controls, invalidates caches
// - reset clears translation and transparent enables
// - reset fetches stack pointer then program counter
// - reset keeps translation cache, stacks nothing
// - reset instruction drives line out only
// - data fault immediate, prefetch fault deferred
// - fault on later burst access: abort only
// - miss aborts, walks tables, retries
// - retry faults only after failed walk
// - fault entry: copy SR, supervisor, vector two
// - stacked PC is executing instruction address
// - short frame at boundary, long otherwise
// - fault in critical processing: halt until reset
`timescale 1ns/100ps
module rbe_seq #(
   parameter int RST_OUT_CYC = rbe_pkg::RST_OUT_CYC_DEF
) (
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   input  wire logic                 reset_pin_in_n,
   output logic                      reset_pin_out_n,
   output logic                      reset_pin_oe,
   input  wire logic                 bus_fault_input,
   input  wire rbe_pkg::rbe_core_ev_t ev,
   input  wire logic                 vec_ack,
   input  wire logic                 vec_err,
   input  wire logic [31:0]          vec_data,
   output logic                      vec_req,
   output logic [31:0]               vec_addr,
   output logic                      status_stb,
   output logic                      abort_o,
   output logic                      burst_abort,
   output logic                      walk_req,
   output logic                      retry_o,
   output logic                      cache_inval,
   output logic                      exc_start,
   output logic                      halted,
   output rbe_pkg::rbe_arch_t        arch,
   output rbe_pkg::rbe_frame_t       frame
);
   import rbe_pkg::*;

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (RST_OUT_CYC < 1 || RST_OUT_CYC > 250) begin : g_chk
      $error("RST_OUT_CYC out of range");
   end
   if (NUM_VEC != FIXED_VEC + USER_VEC) begin : g_vchk
      $error("vector table split inconsistent");
   end

   localparam logic [7:0] ROUT_LOAD = 8'(RST_OUT_CYC + RST_BLANK_CYC);
   localparam logic [7:0] ROUT_BLNK = 8'(RST_BLANK_CYC);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic bf_s1, bf_s2, rp_s1, rp_s2;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bf_s1 <= 1'b0;
         bf_s2 <= 1'b0;
         rp_s1 <= 1'b1;
         rp_s2 <= 1'b1;
      end else begin
         bf_s1 <= bus_fault_input;
         bf_s2 <= bf_s1;
         rp_s1 <= reset_pin_in_n;
         rp_s2 <= rp_s1;
      end
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   rbe_state_t st_reg, st_next;
   rbe_arch_t  arch_reg, arch_next;
   rbe_frame_t frm_reg, frm_next;
   logic [1:0]  stb_reg, stb_next;
   logic [7:0]  rout_reg, rout_next;
   logic [31:0] va_reg, va_next;
   logic        defer_reg, defer_next;
   logic        wflt_reg, wflt_next;
   logic        crit_reg, crit_next;
   logic        abort_reg, abort_next;
   logic        babort_reg, babort_next;
   logic        retry_reg, retry_next;
   logic        inval_reg, inval_next;
   logic        estart_reg, estart_next;
   logic        wr_reg, wr_next;
   logic [7:0]  wa_reg, wa_next;
   logic [31:0] rd_reg, rd_next;
   logic        pin_low, bf, do_exc;

   // own drive of the line must not look like an external reset
   assign pin_low = ~rp_s2 & (rout_reg == 8'h00);
   assign bf      = bf_s2 & (ev.cyc_data | ev.cyc_fetch);

   always_comb begin
      logic [7:0] evec;
      logic       crit;
      logic [1:0] slen;
      evec = VEC_BUS_ERR;
      crit = 1'b0;
      slen = 2'h0;
      do_exc = 1'b0;
      st_next = st_reg;
      arch_next = arch_reg;
      frm_next = frm_reg;
      va_next = va_reg;
      defer_next = defer_reg;
      wflt_next = wflt_reg;
      crit_next = crit_reg;
      abort_next = 1'b0;
      babort_next = 1'b0;
      retry_next = 1'b0;
      inval_next = 1'b0;
      estart_next = 1'b0;
      rout_next = (rout_reg != 8'h00) ? rout_reg - 8'h01 : 8'h00;
      // software writes in the data phase
      if (wr_reg) begin
         case (wa_reg)
            OFF_SR:   arch_next.sr = hwdata[15:0];
            OFF_VBR:  arch_next.vbr = hwdata;
            OFF_CACR: arch_next.cacr = hwdata[6:0];
            OFF_MMU:  arch_next.mmu = hwdata[2:0];
            default: ;
         endcase
      end
      case (st_reg)
         ST_RST_HOLD: begin
            arch_next.sr[SR_T1] = 1'b0;
            arch_next.sr[SR_T0] = 1'b0;
            arch_next.sr[SR_S] = 1'b1;
            arch_next.sr[SR_M] = 1'b0;
            arch_next.sr[SR_IPM_LO +: 3] = IPM_MAX;
            arch_next.vbr = VBR_RST;
            arch_next.cacr = 7'h00;
            inval_next = 1'b1;
            arch_next.mmu = 3'h0;
            defer_next = 1'b0;
            wflt_next = 1'b0;
            crit_next = 1'b1;
            // first long word at offset zero
            va_next = VBR_RST + {22'h0, VEC_RESET, 2'b00};
            if (!pin_low) begin
               st_next = ST_RST_SP;
               slen = STB_EXC;
            end
         end
         ST_RST_SP, ST_RST_PC: begin
            if (vec_err || ev.addr_err) begin
               st_next = ST_HALT;
            end else if (vec_ack) begin
               if (st_reg == ST_RST_SP) begin
                  arch_next.interrupt_stack_pointer = vec_data;
                  va_next = va_reg + VEC_STEP;
                  st_next = ST_RST_PC;
               end else begin
                  arch_next.pc = vec_data;
                  crit_next = 1'b0;
                  st_next = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (ev.rte_restore && bf_s2) begin
               st_next = ST_HALT;
            end else if (bf && ev.cyc_burst_later) begin
               babort_next = 1'b1;
            end else if (bf && ev.cyc_data) begin
               abort_next = 1'b1;
               do_exc = 1'b1;
               crit = 1'b1;
            end else if (ev.tc_miss) begin
               abort_next = 1'b1;
               wflt_next = 1'b0;
               st_next = ST_WALK;
               slen = STB_EXC;
            end else if (ev.addr_err) begin
               do_exc = 1'b1;
               evec = VEC_ADR_ERR;
               crit = 1'b1;
            end else if (defer_reg && ev.fetch_use) begin
               defer_next = 1'b0;
               do_exc = 1'b1;
               crit = 1'b1;
            end else if (ev.seq_exc) begin
               do_exc = 1'b1;
               evec = ev.exc_vec;
            end else if (ev.exec_exc) begin
               do_exc = 1'b1;
               evec = ev.exc_vec;
            end else if (ev.boundary) begin
               slen = (ev.pend_trace || ev.pend_irq) ? STB_PEND : STB_BOUND;
            end
            if (bf && ev.cyc_fetch && !ev.cyc_burst_later) begin
               abort_next = 1'b1;
               defer_next = 1'b1;
            end
            // drive line out, no internal change
            if (ev.reset_insn && rout_reg == 8'h00) begin
               rout_next = ROUT_LOAD;
            end
         end
         ST_WALK: begin
            if (bf_s2 || ev.walk_fault) begin
               wflt_next = 1'b1;
            end
            if (ev.walk_done) begin
               // retry fault only after failed walk
               if (wflt_reg || ev.walk_fault || bf_s2) begin
                  do_exc = 1'b1;
                  crit = 1'b1;
               end else begin
                  retry_next = 1'b1;
                  st_next = ST_RUN;
               end
            end
         end
         ST_EXC: begin
            if ((bf_s2 || ev.addr_err) && crit_reg) begin
               st_next = ST_HALT;
            end else if (bf) begin
               do_exc = 1'b1;
               crit = 1'b1;
            end else if (ev.exc_done) begin
               crit_next = 1'b0;
               st_next = ST_RUN;
            end
         end
         ST_HALT: ;
         default: st_next = ST_RST_HOLD;
      endcase
      if (do_exc) begin
         frm_next.sr = arch_reg.sr;
         arch_next.sr[SR_S] = 1'b1;
         arch_next.sr[SR_T1] = 1'b0;
         arch_next.sr[SR_T0] = 1'b0;
         frm_next.vec = evec;
         frm_next.user = (evec >= VEC_USER_LO);
         frm_next.vaddr = arch_reg.vbr + {22'h0, evec, 2'b00};
         frm_next.pc = ev.cur_pc;
         frm_next.fmt = ev.at_boundary ? FMT_SHORT : FMT_LONG;
         crit_next = crit;
         estart_next = 1'b1;
         st_next = ST_EXC;
         if (!(ev.exec_exc && evec == ev.exc_vec && !crit && !ev.seq_exc)) begin
            slen = STB_EXC;
         end
      end
      if (pin_low) begin
         st_next = ST_RST_HOLD;
         abort_next = (st_reg != ST_RST_HOLD);
         estart_next = 1'b0;
         slen = 2'h0;
      end
      if (slen != 2'h0) begin
         stb_next = slen;
      end else begin
         stb_next = (stb_reg != 2'h0) ? stb_reg - 2'h1 : 2'h0;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   always_comb begin
      wr_next = hsel & htrans[1] & hready & hwrite;
      wa_next = haddr[7:0];
      rd_next = rd_reg;
      if (hsel && htrans[1] && hready && !hwrite) begin
         case (haddr[7:0])
            OFF_SR:    rd_next = {16'h0, arch_reg.sr};
            OFF_VBR:   rd_next = arch_reg.vbr;
            OFF_CACR:  rd_next = {25'h0, arch_reg.cacr};
            OFF_MMU:   rd_next = {29'h0, arch_reg.mmu};
            OFF_ISP:   rd_next = arch_reg.interrupt_stack_pointer;
            OFF_PC:    rd_next = arch_reg.pc;
            OFF_FAULT: rd_next = {frm_reg.sr, 1'b0, frm_reg.user, st_reg == ST_HALT,
                                  defer_reg, frm_reg.fmt, frm_reg.vec};
            OFF_FPC:   rd_next = frm_reg.pc;
            OFF_FVA:   rd_next = frm_reg.vaddr;
            default:   rd_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= ST_RST_HOLD;
         arch_reg <= '0;
         frm_reg <= '0;
         stb_reg <= 2'h0;
         rout_reg <= 8'h00;
         va_reg <= 32'h0;
         defer_reg <= 1'b0;
         wflt_reg <= 1'b0;
         crit_reg <= 1'b0;
         abort_reg <= 1'b0;
         babort_reg <= 1'b0;
         retry_reg <= 1'b0;
         inval_reg <= 1'b0;
         estart_reg <= 1'b0;
         wr_reg <= 1'b0;
         wa_reg <= 8'h00;
         rd_reg <= 32'h0;
      end else begin
         st_reg <= st_next;
         arch_reg <= arch_next;
         frm_reg <= frm_next;
         stb_reg <= stb_next;
         rout_reg <= rout_next;
         va_reg <= va_next;
         defer_reg <= defer_next;
         wflt_reg <= wflt_next;
         crit_reg <= crit_next;
         abort_reg <= abort_next;
         babort_reg <= babort_next;
         retry_reg <= retry_next;
         inval_reg <= inval_next;
         estart_reg <= estart_next;
         wr_reg <= wr_next;
         wa_reg <= wa_next;
         rd_reg <= rd_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_reg;
   assign reset_pin_out_n = 1'b0;
   assign reset_pin_oe = (rout_reg > ROUT_BLNK);
   assign vec_req = (st_reg == ST_RST_SP) || (st_reg == ST_RST_PC);
   assign vec_addr = va_reg;
   assign status_stb = (stb_reg != 2'h0) || (st_reg == ST_HALT);
   assign halted = (st_reg == ST_HALT);
   assign walk_req = (st_reg == ST_WALK);
   assign abort_o = abort_reg;
   assign burst_abort = babort_reg;
   assign retry_o = retry_reg;
   assign cache_inval = inval_reg;
   assign exc_start = estart_reg;
   assign arch = arch_reg;
   assign frame = frm_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic quiet;
   assign quiet = !pin_low && !bf_s2 && !ev.tc_miss && !ev.addr_err && !defer_reg
                  && !ev.seq_exc && !ev.exec_exc && !ev.rte_restore;

   property p_bound_one;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_RUN && quiet && ev.boundary && !ev.pend_trace && !ev.pend_irq)
      |=> status_stb ##1 (stb_reg == 2'h0 || $past(ev.boundary) || exc_start);
   endproperty
   a_bound_one: assert property (p_bound_one) else $error("boundary strobe length");

   property p_bound_pend;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_RUN && quiet && ev.boundary && ev.pend_irq) |=> stb_reg == STB_PEND;
   endproperty
   a_bound_pend: assert property (p_bound_pend) else $error("pending strobe length");

   property p_miss;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_RUN && !pin_low && !bf_s2 && !ev.rte_restore && ev.tc_miss)
      |=> (stb_reg == STB_EXC) && walk_req && abort_o;
   endproperty
   a_miss: assert property (p_miss) else $error("miss strobe or walk missing");

   property p_halt;
      @(posedge core_clk) disable iff (sys_rst)
      halted && !pin_low |=> halted && status_stb;
   endproperty
   a_halt: assert property (p_halt) else $error("halt left or strobe dropped");

   property p_exec;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_RUN && stb_reg == 2'h0 && !pin_low && !bf_s2 && !ev.tc_miss
       && !ev.addr_err && !defer_reg && !ev.seq_exc && ev.exec_exc)
      |=> !status_stb && exc_start;
   endproperty
   a_exec: assert property (p_exec) else $error("strobe on execution exception");

   property p_rst_init;
      @(posedge core_clk) disable iff (sys_rst)
      st_reg == ST_RST_HOLD |=> arch.sr[SR_IPM_LO +: 3] == IPM_MAX && arch.vbr == VBR_RST
                                && arch.mmu == 3'h0 && arch.cacr == 7'h00 && cache_inval;
   endproperty
   a_rst_init: assert property (p_rst_init) else $error("reset init wrong");

   property p_fault_entry;
      @(posedge core_clk) disable iff (sys_rst)
      exc_start && frame.vec == VEC_BUS_ERR |->
         arch.sr[SR_S] && !arch.sr[SR_T1] && !arch.sr[SR_T0] && frame.vaddr == arch.vbr + 32'h8;
   endproperty
   a_fault_entry: assert property (p_fault_entry) else $error("bus fault entry wrong");

   property p_rst_insn;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_RUN && !pin_low && ev.reset_insn && rout_reg == 8'h00)
      |=> reset_pin_oe;
   endproperty
   a_rst_insn: assert property (p_rst_insn) else $error("reset line not driven");

   // drive length counter, judged when the line is let go
   logic [7:0] oe_len_reg, oe_len_next;
   assign oe_len_next = reset_pin_oe ? oe_len_reg + 8'h01 : 8'h00;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         oe_len_reg <= 8'h00;
      end else begin
         oe_len_reg <= oe_len_next;
      end
   end

   property p_rst_len;
      @(posedge core_clk) disable iff (sys_rst)
      $fell(reset_pin_oe) |-> oe_len_reg == 8'(RST_OUT_CYC);
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset line drive length");

   property p_burst;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_RUN && !pin_low && !ev.rte_restore && bf && ev.cyc_burst_later)
      |=> burst_abort && !exc_start && st_reg == ST_RUN;
   endproperty
   a_burst: assert property (p_burst) else $error("burst fault raised exception");

   property p_dbl;
      @(posedge core_clk) disable iff (sys_rst)
      (st_reg == ST_EXC && crit_reg && bf_s2 && !pin_low) |=> halted;
   endproperty
   a_dbl: assert property (p_dbl) else $error("double fault not halted");

   c_reset_seq: cover property (@(posedge core_clk) disable iff (sys_rst)
      st_reg == ST_RST_PC && vec_ack ##1 st_reg == ST_RUN);
   c_walk_retry: cover property (@(posedge core_clk) disable iff (sys_rst)
      walk_req ##[1:20] retry_o);
   c_halt: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(halted));

endmodule

/* hdl/rbe_pkg.sv */
// constants, types and register map of the exception sequencer
// assumes one core clock; core logic supplies sequencer events on that clock
package rbe_pkg;

   // vector table
   localparam int          NUM_VEC     = 256;
   localparam int          FIXED_VEC   = 64;
   localparam int          USER_VEC    = 192;
   localparam int          VEC_SHIFT   = 2;
   localparam logic [7:0]  VEC_RESET   = 8'h00;
   localparam logic [7:0]  VEC_BUS_ERR = 8'h02;
   localparam logic [7:0]  VEC_ADR_ERR = 8'h03;
   localparam logic [7:0]  VEC_USER_LO = 8'h40;
   localparam logic [31:0] VEC_STEP    = 32'h0000_0004;

   // status register fields
   localparam int          SR_T1     = 15;
   localparam int          SR_T0     = 14;
   localparam int          SR_S      = 13;
   localparam int          SR_M      = 12;
   localparam int          SR_IPM_LO = 8;
   localparam logic [2:0]  IPM_MAX   = 3'h7;
   localparam logic [31:0] VBR_RST   = 32'h0000_0000;

   // frame format codes
   localparam logic [3:0]  FMT_SHORT = 4'ha;
   localparam logic [3:0]  FMT_LONG  = 4'hb;

   // status strobe lengths in clocks
   localparam logic [1:0]  STB_BOUND = 2'h1;
   localparam logic [1:0]  STB_PEND  = 2'h2;
   localparam logic [1:0]  STB_EXC   = 2'h3;

   // outward reset drive length and resync blanking
   localparam int          RST_OUT_CYC_DEF = 16;
   localparam int          RST_BLANK_CYC   = 3;

   // register offsets (byte addresses)
   localparam logic [7:0]  OFF_SR    = 8'h00;
   localparam logic [7:0]  OFF_VBR   = 8'h04;
   localparam logic [7:0]  OFF_CACR  = 8'h08;
   localparam logic [7:0]  OFF_MMU   = 8'h0c;
   localparam logic [7:0]  OFF_ISP   = 8'h10;
   localparam logic [7:0]  OFF_PC    = 8'h14;
   localparam logic [7:0]  OFF_FAULT = 8'h18;
   localparam logic [7:0]  OFF_FPC   = 8'h1c;
   localparam logic [7:0]  OFF_FVA   = 8'h20;

   typedef enum logic [2:0] {
      ST_RST_HOLD, ST_RST_SP, ST_RST_PC, ST_RUN, ST_WALK, ST_EXC, ST_HALT
   } rbe_state_t;

   // events from the core pipeline, same clock
   typedef struct packed {
      logic        boundary;
      logic        pend_trace;
      logic        pend_irq;
      logic        tc_miss;
      logic        walk_done;
      logic        walk_fault;
      logic        seq_exc;
      logic        exec_exc;
      logic [7:0]  exc_vec;
      logic        addr_err;
      logic        cyc_data;
      logic        cyc_fetch;
      logic        cyc_burst_later;
      logic        fetch_use;
      logic        at_boundary;
      logic        rte_restore;
      logic        exc_done;
      logic        reset_insn;
      logic [31:0] cur_pc;
   } rbe_core_ev_t;

   // architectural state held here
   typedef struct packed {
      logic [15:0] sr;
      logic [31:0] vbr;
      logic [6:0]  cacr;
      logic [2:0]  mmu;
      logic [31:0] interrupt_stack_pointer;
      logic [31:0] pc;
   } rbe_arch_t;

   // last exception frame content
   typedef struct packed {
      logic        user;
      logic [7:0]  vec;
      logic [3:0]  fmt;
      logic [15:0] sr;
      logic [31:0] pc;
      logic [31:0] vaddr;
   } rbe_frame_t;

endpackage

/* bench/rbe_sys_model.sv */
// partner: system memory answering the reset vector fetch
// assumes single-cycle ack pulses sampled while vec_req is high
`timescale 1ns/100ps
module rbe_sys_model (
   input  wire logic        core_clk,
   input  wire logic        slow,
   input  wire logic        vec_req,
   input  wire logic [31:0] vec_addr,
   output logic             vec_ack = 1'b0,
   output logic             vec_err,
   output logic [31:0]      vec_data = 32'h0
);
   logic tick = 1'b0;
   assign vec_err = 1'b0;
   always_ff @(posedge core_clk) begin
      tick     <= ~tick;
      vec_ack  <= vec_req & ~vec_ack & (~slow | tick);
      vec_data <= (vec_req & ~vec_ack) ? (32'h0000_1000 | vec_addr) : ~vec_data;
   end
endmodule

/* bench/reset_bus_error_exception_sequencer_test.sv */
// bench: core events, fault pin, reset pin and ahb against the sequencer
// assumes rbe_sys_model answers the vector fetch
`timescale 1ns/100ps
module reset_bus_error_exception_sequencer_test;
   import rbe_pkg::*;
   logic         core_clk, hreadyout, vec_req, vec_ack, vec_err, halted, hresp, rpo_n;
   wire logic [7:0] obs;
   logic         sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic         rpin_n = 1'b1, bus_fault_input = 1'b0;
   logic [1:0]   htrans = 2'h0;
   logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, vec_addr, vec_data, rd;
   rbe_core_ev_t ev = '0;
   rbe_arch_t    arch;
   rbe_frame_t   frame;
   int           n_mismatch = 0, n_checks = 0;
   rbe_seq #(.RST_OUT_CYC(2)) uut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .reset_pin_in_n(rpin_n & (rpo_n | ~obs[7])), .reset_pin_out_n(rpo_n),
      .reset_pin_oe(obs[7]), .bus_fault_input, .ev, .vec_ack, .vec_err, .vec_data, .vec_req,
      .vec_addr, .status_stb(obs[0]), .abort_o(obs[1]), .burst_abort(obs[2]),
      .walk_req(obs[3]), .retry_o(obs[4]), .cache_inval(obs[5]), .exc_start(obs[6]), .halted,
      .arch, .frame);
   rbe_sys_model sys (.core_clk, .slow, .vec_req, .vec_addr, .vec_ack, .vec_err, .vec_data);
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cnt(input logic [7:0] m, output logic [31:0] n);
      n = 32'h0;
      repeat (8) @(negedge core_clk) n += $countones(obs & m);
   endtask
   task automatic evp(input rbe_core_ev_t v, f, input logic [7:0] m, output logic [31:0] n);
      @(posedge core_clk) ev <= v;
      @(posedge core_clk) ev <= '0;
      cnt(m, n);
      @(posedge core_clk) ev <= f;
      @(posedge core_clk) ev <= '0;
   endtask
   task automatic fin;
      @(posedge core_clk) ev.exc_done <= 1'b1;
      @(posedge core_clk) ev <= '0;
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] d);
      @(posedge core_clk) begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= w;
      end
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic pin;
      @(posedge core_clk) bus_fault_input <= 1'b1;
      @(posedge core_clk) bus_fault_input <= 1'b0;
   endtask
   task automatic t_reset(input logic [31:0] e);
      cnt(8'h21, rd);
      chk(rd, e);
      repeat (12) @(posedge core_clk);
      chk(arch.sr, 32'h2700);
      chk(arch.vbr, 32'h0);
      chk({arch.cacr, arch.mmu}, 32'h0);
      chk(arch.interrupt_stack_pointer, 32'h0000_1000);
      chk(arch.pc, 32'h0000_1004);
   endtask
   task automatic t_ahb;
      ahb(1'b1, OFF_VBR, 32'h0000_0100, rd);
      ahb(1'b0, OFF_VBR, 32'h0, rd);
      chk(rd, 32'h0000_0100);
      ahb(1'b0, 32'h40, 32'h0, rd);
      chk(rd, 32'h0);
      chk(hresp, 32'h0);
   endtask
   task automatic t_strobe;
      rbe_core_ev_t v, f;
      v = '0;
      f = '0;
      f.exc_done = 1'b1;
      v.boundary = 1'b1;
      evp(v, '0, 8'h01, rd);
      chk(rd, 32'h1);
      v.pend_irq = 1'b1;
      evp(v, '0, 8'h01, rd);
      chk(rd, 32'h2);
      v.pend_irq = 1'b0;
      v.pend_trace = 1'b1;
      evp(v, '0, 8'h01, rd);
      chk(rd, 32'h2);
      v = '0;
      v.exec_exc = 1'b1;
      evp(v, f, 8'h01, rd);
      chk(rd, 32'h0);
   endtask
   task automatic t_misc;
      rbe_core_ev_t v, f;
      v = '0;
      f = '0;
      v.cyc_fetch = 1'b1;
      v.cyc_burst_later = 1'b1;
      pin();
      evp(v, f, 8'h47, rd);
      chk(rd, 32'h1);
      v.cyc_burst_later = 1'b0;
      f.fetch_use = 1'b1;
      pin();
      evp(v, f, 8'h43, rd);
      chk(rd, 32'h1);
      @(negedge core_clk) chk(obs[6], 32'h1);
      fin();
      v = '0;
      v.tc_miss = 1'b1;
      f = '0;
      f.walk_done = 1'b1;
      evp(v, f, 8'h03, rd);
      chk(rd, 32'h4);
      @(negedge core_clk) chk(obs[4:3], 32'h2);
      f.walk_fault = 1'b1;
      evp(v, f, 8'h08, rd);
      chk(rd, 32'h8);
      @(negedge core_clk) chk({obs[6], frame.fmt}, 32'h1b);
      fin();
      v = '0;
      v.reset_insn = 1'b1;
      evp(v, '0, 8'h81, rd);
      chk(rd, 32'h2);
      chk(arch.pc, 32'h0000_1004);
   endtask
   task automatic t_fault;
      rbe_core_ev_t v;
      v = '0;
      v.cyc_data = 1'b1;
      v.at_boundary = 1'b1;
      v.cur_pc = 32'h0000_0400;
      pin();
      evp(v, '0, 8'h01, rd);
      chk(rd, 32'h3);
      chk(frame.vec, VEC_BUS_ERR);
      chk(arch.sr[15:13], 32'h1);
      chk(frame.fmt, FMT_SHORT);
      chk(frame.pc, 32'h0000_0400);
      pin();
      repeat (4) @(posedge core_clk);
      chk(halted, 1'b1);
      cnt(8'h01, rd);
      chk(rd, 32'h8);
   endtask
   task automatic t_pin_reset;
      @(posedge core_clk) rpin_n <= 1'b0;
      slow <= 1'b1;
      repeat (8) @(posedge core_clk);
      rpin_n <= 1'b1;
      t_reset(32'h7);
      chk(halted, 1'b0);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset(32'h4);
      t_ahb();
      t_strobe();
      t_misc();
      t_fault();
      t_pin_reset();
      end_of_test();
   end
   initial begin
      #20000;
      n_mismatch++;
      end_of_test();
   end
endmodule
